// ---- rtl/amp_fault_pkg.sv ----
// Package of constants for the amplifier fault supervision block.
`default_nettype none
package amp_fault_pkg;
   // ==================================================================
   // Timing and widths
   // ==================================================================
   localparam int CLK_HZ = 10_000_000;
   localparam int SYNC_STAGES = 2;
   localparam int NUM_BRIDGES = 6;
   // Overload counter time in microseconds, as a least time.
   localparam int OVERLOAD_TIME_US = 1250;
   localparam int OVERLOAD_CYCLES =
      (OVERLOAD_TIME_US * (CLK_HZ / 1_000_000) + 0) > 0 ?
      OVERLOAD_TIME_US * (CLK_HZ / 1_000_000) : 1;
   // Controller wait before overload reset, in milliseconds.
   localparam int OVERLOAD_RESET_WAIT_MS = 1000;
   // ==================================================================
   // Fault vector field positions
   // ==================================================================
   localparam int FAULT_WIDTH = 5;
   localparam int FLD_OTW = 0;
   localparam int FLD_OTE = 1;
   localparam int FLD_OVC = 2;
   localparam int FLD_UVG = 3;
   localparam int FLD_UVC = 4;
   localparam logic [FAULT_WIDTH-1:0] FAULT_RESET = 5'h00;
   localparam logic STATUS_RELEASED = 1'b1;
   typedef enum logic [1:0] {
      ST_POWERUP,
      ST_RUN,
      ST_SHUTDOWN,
      ST_OVERLOAD
   } stage_state_t;
endpackage : amp_fault_pkg
`default_nettype wire

// ---- rtl/fault_sync.sv ----
// Two-flop synchronizer for one fault condition input.
`default_nettype none
module fault_sync #(
   parameter int STAGES = 2
) (
   mclk,
   rst,
   async_in,
   sync_out
);
   input wire logic mclk;
   input wire logic rst;
   input wire logic async_in;
   output logic sync_out;
   logic [STAGES-1:0] chain_reg;
   // ==================================================================
   // Chain
   // ==================================================================
   // The first stage feeds only the next stage, never other logic.
   always_ff @(posedge mclk) begin
      if (rst) begin
         chain_reg <= '0;
      end else begin
         chain_reg <= {chain_reg[STAGES-2:0], async_in};
      end
   end
   assign sync_out = chain_reg[STAGES-1];
endmodule : fault_sync
`default_nettype wire

// ---- rtl/amp_fault_status.sv ----
// Fault supervision and status reporting for a multichannel power stage.
`default_nettype none
module amp_fault_status #(
   parameter int NUM_BRIDGES = amp_fault_pkg::NUM_BRIDGES,
   parameter int OVERLOAD_CYCLES = amp_fault_pkg::OVERLOAD_CYCLES
) (
   mclk,
   rst,
   reset_n,
   overtemp_warning,
   overtemp_error,
   overcurrent,
   gate_drive_supply_low,
   common_supply_low,
   shutdown_fault_n_in,
   shutdown_fault_n_out,
   shutdown_fault_n_oe,
   overtemp_warning_n_in,
   overtemp_warning_n_out,
   overtemp_warning_n_oe,
   bridge_enable,
   overload_protect,
   undervoltage_protect
);
   input wire logic mclk;
   input wire logic rst;
   input wire logic reset_n;
   input wire logic overtemp_warning;
   input wire logic overtemp_error;
   input wire logic overcurrent;
   input wire logic gate_drive_supply_low;
   input wire logic common_supply_low;
   input wire logic shutdown_fault_n_in;
   output logic shutdown_fault_n_out;
   output logic shutdown_fault_n_oe;
   input wire logic overtemp_warning_n_in;
   output logic overtemp_warning_n_out;
   output logic overtemp_warning_n_oe;
   output logic [NUM_BRIDGES-1:0] bridge_enable;
   output logic overload_protect;
   output logic undervoltage_protect;

   localparam int CW = $clog2(OVERLOAD_CYCLES + 1);
   localparam int SS = amp_fault_pkg::SYNC_STAGES;

   // ==================================================================
   // Input synchronization
   // ==================================================================
   logic [amp_fault_pkg::FAULT_WIDTH-1:0] raw_faults;
   logic [amp_fault_pkg::FAULT_WIDTH-1:0] sync_faults;
   logic reset_n_sync;
   assign raw_faults[amp_fault_pkg::FLD_OTW] = overtemp_warning;
   assign raw_faults[amp_fault_pkg::FLD_OTE] = overtemp_error;
   assign raw_faults[amp_fault_pkg::FLD_OVC] = overcurrent;
   assign raw_faults[amp_fault_pkg::FLD_UVG] = gate_drive_supply_low;
   assign raw_faults[amp_fault_pkg::FLD_UVC] = common_supply_low;

   genvar gi;
   generate
      for (gi = 0; gi < amp_fault_pkg::FAULT_WIDTH; gi++) begin : g_sync
         fault_sync #(.STAGES(amp_fault_pkg::SYNC_STAGES)) u_sync (
            .mclk(mclk),
            .rst(rst),
            .async_in(raw_faults[gi]),
            .sync_out(sync_faults[gi])
         );
      end
   endgenerate

   // Reset pin is sampled as a synchronous input; one register gives
   // the previous level for edge detection.
   assign reset_n_sync = reset_n;

   // ==================================================================
   // Decode
   // ==================================================================
   wire otw_active = sync_faults[amp_fault_pkg::FLD_OTW];
   wire ote_active = sync_faults[amp_fault_pkg::FLD_OTE];
   wire ovc_active = sync_faults[amp_fault_pkg::FLD_OVC];
   wire uv_active = sync_faults[amp_fault_pkg::FLD_UVG] |
                    sync_faults[amp_fault_pkg::FLD_UVC];

   logic reset_n_prev_reg;
   logic overload_latch_reg;
   logic overload_latch_next;
   logic [CW-1:0] ovc_count_reg;
   logic [CW-1:0] ovc_count_next;
   amp_fault_pkg::stage_state_t state_reg;
   amp_fault_pkg::stage_state_t state_next;
   logic sd_low_reg;
   logic otw_low_reg;
   logic [NUM_BRIDGES-1:0] bridge_en_reg;
   logic [SS-1:0] settle_reg;
   logic uv_flag_reg;
   wire settled = settle_reg[SS-1];

   wire reset_rise = reset_n_sync & ~reset_n_prev_reg;
   wire ovc_expired = (ovc_count_reg == CW'(OVERLOAD_CYCLES - 1));

   // Overcurrent must persist for the whole counter window; the
   // current limiter handles short transients without shutdown.
   always_comb begin
      ovc_count_next = '0;
      if (ovc_active && !overload_latch_reg && !ovc_expired) begin
         ovc_count_next = ovc_count_reg + CW'(1);
      end
   end

   // Latched overload set wins over a coincident reset edge clear.
   always_comb begin
      overload_latch_next = overload_latch_reg;
      if (ovc_active && ovc_expired) begin
         overload_latch_next = 1'b1;
      end else if (reset_rise) begin
         overload_latch_next = 1'b0;
      end
   end

   wire auto_fault = ote_active | uv_active;
   wire any_fault = auto_fault | overload_latch_next;

   // ==================================================================
   // Power stage sequencing
   // ==================================================================
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         amp_fault_pkg::ST_POWERUP: begin
            if (settled && !uv_active && !overload_latch_next) begin
               state_next = amp_fault_pkg::ST_RUN;
            end
         end
         amp_fault_pkg::ST_RUN: begin
            if (overload_latch_next) begin
               state_next = amp_fault_pkg::ST_OVERLOAD;
            end else if (auto_fault) begin
               state_next = amp_fault_pkg::ST_SHUTDOWN;
            end
         end
         amp_fault_pkg::ST_SHUTDOWN: begin
            if (overload_latch_next) begin
               state_next = amp_fault_pkg::ST_OVERLOAD;
            end else if (!auto_fault) begin
               state_next = amp_fault_pkg::ST_RUN;
            end
         end
         amp_fault_pkg::ST_OVERLOAD: begin
            if (!overload_latch_next) begin
               state_next = auto_fault ? amp_fault_pkg::ST_SHUTDOWN :
                            amp_fault_pkg::ST_RUN;
            end
         end
         default: begin
            state_next = amp_fault_pkg::ST_POWERUP;
         end
      endcase
   end

   wire run_ok = (state_next == amp_fault_pkg::ST_RUN) & ~any_fault;
   wire bridges_on = run_ok & reset_n_sync;
   wire sd_low_next = any_fault & reset_n_sync;
   wire otw_low_next = (otw_active | ote_active) & reset_n_sync;

   // ==================================================================
   // Registers
   // ==================================================================
   // The sync chains read as fault free right after rst; until they have
   // refilled, a low supply could look good and start the bridges.
   always_ff @(posedge mclk) begin
      if (rst) begin
         settle_reg <= '0;
      end else begin
         settle_reg <= {settle_reg[SS-2:0], 1'b1};
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= amp_fault_pkg::ST_POWERUP;
         overload_latch_reg <= 1'b0;
         ovc_count_reg <= '0;
      end else begin
         state_reg <= state_next;
         overload_latch_reg <= overload_latch_next;
         ovc_count_reg <= ovc_count_next;
      end
   end

   // The edge detector idles high like the pin, so leaving rst with the
   // pin already high is not taken for a rising edge.
   always_ff @(posedge mclk) begin
      if (rst) begin
         reset_n_prev_reg <= 1'b1;
      end else begin
         reset_n_prev_reg <= reset_n_sync;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sd_low_reg <= 1'b0;
         otw_low_reg <= 1'b0;
         bridge_en_reg <= '0;
         uv_flag_reg <= 1'b0;
      end else begin
         sd_low_reg <= sd_low_next;
         otw_low_reg <= otw_low_next;
         bridge_en_reg <= {NUM_BRIDGES{bridges_on}};
         uv_flag_reg <= uv_active;
      end
   end

   // ==================================================================
   // Open-drain and flag outputs
   // ==================================================================
   // Pins only ever pull low; the high level comes from the pullup.
   assign shutdown_fault_n_out = 1'b0;
   assign shutdown_fault_n_oe = sd_low_reg;
   assign overtemp_warning_n_out = 1'b0;
   assign overtemp_warning_n_oe = otw_low_reg;
   assign bridge_enable = bridge_en_reg;
   assign overload_protect = overload_latch_reg;
   assign undervoltage_protect = uv_flag_reg;

   // Pin readback is not needed by the logic.
   wire unused_pins = shutdown_fault_n_in ^ overtemp_warning_n_in;
endmodule : amp_fault_status
`default_nettype wire

// ---- verification/amp_fault_status_asserts.sv ----
// Port checker of the fault supervision block.
`default_nettype none
module amp_fault_status_asserts #(
   parameter int NUM_BRIDGES = 6,
   parameter int OVERLOAD_CYCLES = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic reset_n,
   input wire logic overtemp_warning,
   input wire logic overtemp_error,
   input wire logic overcurrent,
   input wire logic gate_drive_supply_low,
   input wire logic shutdown_fault_n_out,
   input wire logic shutdown_fault_n_oe,
   input wire logic overtemp_warning_n_out,
   input wire logic overtemp_warning_n_oe,
   input wire logic [NUM_BRIDGES-1:0] bridge_enable,
   input wire logic overload_protect
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==================================================================
   // Overcurrent run length
   // ==================================================================
   // Saturates so that a long overload cannot wrap the count.
   int oc_cnt;
   always_ff @(posedge mclk) begin
      if (rst || !overcurrent || !reset_n) oc_cnt <= 0;
      else if (oc_cnt < 255) oc_cnt <= oc_cnt + 1;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   chk_drive_low: assert property (shutdown_fault_n_out == 1'b0 &&
      overtemp_warning_n_out == 1'b0) else $error("status drive not low");
   chk_reset_release: assert property (!reset_n |=>
      !shutdown_fault_n_oe && !overtemp_warning_n_oe)
      else $error("status not released in reset");
   chk_reset_hiz: assert property (!reset_n |=> bridge_enable == '0)
      else $error("bridges on in reset");
   chk_error_stop: assert property ((overtemp_error && reset_n)[*3] |=>
      shutdown_fault_n_oe && overtemp_warning_n_oe && bridge_enable == '0)
      else $error("no thermal shutdown");
   chk_supply_stop: assert property (
      (gate_drive_supply_low && reset_n)[*3] |=>
      shutdown_fault_n_oe && bridge_enable == '0)
      else $error("no undervoltage shutdown");
   chk_warn_low: assert property (
      (overtemp_warning && reset_n)[*3] |=> overtemp_warning_n_oe)
      else $error("warning not shown");
   chk_bridge_all: assert property (bridge_enable != '0 |->
      bridge_enable == '1 && !shutdown_fault_n_oe)
      else $error("bridges on during shutdown");
   chk_latch_hold: assert property (overload_protect && reset_n &&
      $past(reset_n) && $past(reset_n, 2) |=> overload_protect)
      else $error("overload latch dropped");
   chk_latch_set: assert property (
      oc_cnt >= OVERLOAD_CYCLES + 4 |-> overload_protect)
      else $error("overload not latched");
   chk_latch_early: assert property (
      $rose(overload_protect) |-> oc_cnt >= OVERLOAD_CYCLES)
      else $error("overload latched early");
   cover property (overload_protect ##1 !overload_protect);
   cover property (shutdown_fault_n_oe && !overtemp_warning_n_oe);
   cover property (overtemp_warning_n_oe && !shutdown_fault_n_oe);
endmodule : amp_fault_status_asserts
bind amp_fault_status amp_fault_status_asserts #(
   .NUM_BRIDGES(NUM_BRIDGES),
   .OVERLOAD_CYCLES(OVERLOAD_CYCLES)
) u_chk (.mclk, .rst, .reset_n, .overtemp_warning, .overtemp_error,
   .overcurrent, .gate_drive_supply_low, .shutdown_fault_n_out,
   .shutdown_fault_n_oe, .overtemp_warning_n_out, .overtemp_warning_n_oe,
   .bridge_enable, .overload_protect);
`default_nettype wire

// ---- verification/fault_monitor.sv ----
// Controller-side model: pulled-up status wires and the reset pin driver.
`default_nettype none
module fault_monitor (
   input wire logic mclk,
   input wire logic hold_low,
   input wire logic shut_oe,
   input wire logic shut_o,
   input wire logic warn_oe,
   input wire logic warn_o,
   output logic shut_pin,
   output logic warn_pin,
   output logic reset_n = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==================================================================
   // Wires and reset pin
   // ==================================================================
   // A released open-drain line floats to its pull-up level.
   assign shut_pin = shut_oe ? shut_o : 1'b1;
   assign warn_pin = warn_oe ? warn_o : 1'b1;
   // Starts low so power-up happens in reset; its rise is the only way
   // out of a latched overload.
   always @(posedge mclk) reset_n <= ~hold_low;
endmodule : fault_monitor
`default_nettype wire

// ---- verification/amp_fault_status_bench.sv ----
// Self-checking bench of the fault supervision block.
`default_nettype none
module amp_fault_status_bench;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
   mismatches++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
   // ==================================================================
   // Stimulus and model state
   // ==================================================================
   logic mclk = 0, rst = 1, warn = 0, err = 0, oc = 0, gd = 1, cs = 1;
   logic hold = 1, ol_m = 0;
   wire shut_oe, shut_o, warn_oe, warn_o, shut_pin, warn_pin, reset_n;
   wire ol_flag, uv_flag;
   wire [5:0] br;
   int mismatches = 0, compares = 0, cycles = 0, seed;
   always #50 mclk = ~mclk;
   amp_fault_status #(.OVERLOAD_CYCLES(8)) u_dut (.mclk(mclk), .rst(rst),
      .reset_n(reset_n), .overtemp_warning(warn), .overtemp_error(err),
      .overcurrent(oc), .gate_drive_supply_low(gd), .common_supply_low(cs),
      .shutdown_fault_n_in(shut_pin), .shutdown_fault_n_out(shut_o),
      .shutdown_fault_n_oe(shut_oe), .overtemp_warning_n_in(warn_pin),
      .overtemp_warning_n_out(warn_o), .overtemp_warning_n_oe(warn_oe),
      .bridge_enable(br), .overload_protect(ol_flag),
      .undervoltage_protect(uv_flag));
   fault_monitor u_mon (.mclk(mclk), .hold_low(hold), .shut_oe(shut_oe),
      .shut_o(shut_o), .warn_oe(warn_oe), .warn_o(warn_o),
      .shut_pin(shut_pin), .warn_pin(warn_pin), .reset_n(reset_n));
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   // Waits past the synchronisers and the pin driver, then compares.
   task automatic check_all;
      logic f;
      f = err | gd | cs | ol_m;
      repeat (6) @(negedge mclk);
      `CHK("shut", ~(~hold & f), shut_pin)
      `CHK("warn", ~(~hold & (warn | err)), warn_pin)
      `CHK("bridges", {6{~hold & ~f}}, br)
      `CHK("overload", ol_m, ol_flag)
      `CHK("uv", gd | cs, uv_flag)
   endtask : check_all
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 1000) begin
         mismatches++;
         wrap_up;
      end
   end
   initial begin
      seed = 32'h129a;
      repeat (4) @(negedge mclk);
      rst = 0;
      check_all;
      hold = 0;
      check_all;
      gd = 0;
      check_all;
      cs = 0;
      check_all;
      for (int i = 0; i < 24; i++) begin
         {hold, err, warn, gd, cs} = 5'($random(seed));
         check_all;
         if (!warn_pin) begin
            {err, warn} = 2'h0;
            check_all;
         end
      end
      {hold, err, warn, gd, cs} = 5'h00;
      oc = 1;
      repeat (5) @(negedge mclk);
      oc = 0;
      check_all;
      oc = 1;
      repeat (16) @(negedge mclk);
      oc = 0;
      ol_m = 1;
      check_all;
      err = 1;
      check_all;
      err = 0;
      check_all;
      repeat (20) @(negedge mclk);
      hold = 1;
      check_all;
      hold = 0;
      ol_m = 0;
      check_all;
      wrap_up;
   end
endmodule : amp_fault_status_bench
`default_nettype wire
